// >>> verilog/imea_pkg.sv
// shared constants and types for the i2c master command engine
`default_nettype none
package imea_pkg;
	// ==========================================================
	// clock and bus timing
	localparam int unsigned CLK_PERIOD_NS  = 40;     // 25 MHz system clock
	localparam int unsigned SCL_QUARTER_NS = 2500;   // quarter of a 100 kHz scl period
	// least time, so round up to whole cycles
	localparam int unsigned QTR_CYCLES     = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned QTR_W          = 7;      // width of the quarter counter
	localparam logic [QTR_W-1:0] QTR_LOAD  = QTR_W'(QTR_CYCLES - 1);
	localparam int unsigned ACK_TIMEOUT_US = 1000;   // longest wait for a released scl
	// longest time, so round down
	localparam int unsigned ACK_TIMEOUT_CYCLES = (ACK_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned TMO_W          = 16;     // width of the timeout counter

	// ==========================================================
	// data memory array and command fields
	localparam int unsigned DM_DEPTH = 256;          // bytes in the data memory array
	localparam int unsigned IDX_W    = 8;            // index width
	localparam int unsigned CNT_W    = 9;            // byte count, 0..256
	localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 9'h001;
	localparam logic [IDX_W-1:0] IDX_ONE  = 8'h01;
	localparam logic [2:0]       BIT_LAST = 3'h7;    // eighth bit of a byte
	localparam logic             RW_WRITE = 1'b0;    // direction bit for a write
	localparam logic             RW_READ  = 1'b1;    // direction bit for a read
	localparam logic             ACK_BIT  = 1'b0;    // sda low on the ninth clock
	localparam logic             NACK_BIT = 1'b1;    // sda released on the ninth clock

	// command codes on the command port
	localparam logic [1:0] CMD_WRITE = 2'h0;
	localparam logic [1:0] CMD_READ  = 2'h1;
	localparam logic [1:0] CMD_STOP  = 2'h2;

	// ==========================================================
	// serial eeprom addressing conventions (kept by the software and the memory)
	localparam logic [6:0]  EE0_LOW_BANK  = 7'h50;   // first memory, lower 64k bytes
	localparam logic [6:0]  EE0_HIGH_BANK = 7'h51;   // first memory, upper 64k bytes
	localparam logic [6:0]  EE1_LOW_BANK  = 7'h52;   // optional memory, lower bank
	localparam logic [6:0]  EE1_HIGH_BANK = 7'h53;   // optional memory, upper bank
	localparam int unsigned EE_PAGE_BYTES = 256;     // page shares address bits 15..8

	// ==========================================================
	// single bit operations asked of the bit engine
	typedef enum logic [1:0] {
		IMEA_BIT_START,
		IMEA_BIT_STOP,
		IMEA_BIT_DATA
	} imea_bit_t;
endpackage
`default_nettype wire

// >>> verilog/imea_bit_engine.sv
// scl and sda waveform generator for one start, stop or data bit
`timescale 1ns/1ps
`default_nettype none
module imea_bit_engine #(
	parameter int unsigned TIMEOUT_CYCLES = imea_pkg::ACK_TIMEOUT_CYCLES
) (
	input  wire logic               clk,         // system clock
	input  wire logic               rst_n,       // async reset, active low
	input  wire logic               bit_go,      // start one bit operation
	input  wire imea_pkg::imea_bit_t bit_op,     // start, stop or data
	input  wire logic               bit_tx,      // bit to send, 1 releases sda
	output logic                    bit_done,    // one-cycle pulse at the end
	output logic                    bit_rx,      // sda sampled while scl high
	output logic                    bit_timeout, // scl held low too long
	input  wire logic               scl_i,       // scl pin level
	input  wire logic               sda_i,       // sda pin level
	output logic                    scl_oe,      // pull scl low when high
	output logic                    sda_oe       // pull sda low when high
);
	// ==========================================================
	// state
	typedef enum logic {BE_IDLE, BE_RUN} imea_be_state_t;
	imea_be_state_t                  state;      // engine state
	imea_pkg::imea_bit_t             op;         // latched operation
	logic                            tx;         // latched data bit
	logic [1:0]                      phase;      // quarter of the bit
	logic [imea_pkg::QTR_W-1:0]      qcnt;       // cycles left in this quarter
	logic [imea_pkg::TMO_W-1:0]      tcnt;       // cycles spent waiting for scl
	logic                            held;       // bus owned since last stop
	logic                            scl_m, scl_s, sda_m, sda_s; // synchronisers
	logic                            next_scl_low, next_sda_low;
	wire                             running  = (state == BE_RUN);
	// scl is released in quarters two and three; a slave may stretch it
	wire                             wait_scl = running && (phase == 2'h1) && !scl_s;
	wire                             q_end    = running && (qcnt == '0) && !wait_scl;
	wire                             tmo_hit  = wait_scl && (tcnt == imea_pkg::TMO_W'(TIMEOUT_CYCLES - 1));

	// ==========================================================
	// pin synchronisers, second stage only is read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			sda_m <= sda_i;
			sda_s <= sda_m;
		end
	end

	// ==========================================================
	// pin drive per quarter; start drops sda while scl high, stop lifts it
	always_comb begin
		next_scl_low = held;
		next_sda_low = 1'b0;
		if (running) begin
			next_scl_low = (phase == 2'h0) || ((phase == 2'h3) && (op != imea_pkg::IMEA_BIT_STOP));
			case (op)
				imea_pkg::IMEA_BIT_START: next_sda_low = phase[1];
				imea_pkg::IMEA_BIT_STOP:  next_sda_low = !phase[1];
				default:                  next_sda_low = !tx;
			endcase
		end
	end

	// ==========================================================
	// quarter sequencer with bounded wait on a stretched scl
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= BE_IDLE;
			op          <= imea_pkg::IMEA_BIT_STOP;
			tx          <= 1'b1;
			phase       <= 2'h0;
			qcnt        <= '0;
			tcnt        <= '0;
			held        <= 1'b0;
			bit_done    <= 1'b0;
			bit_rx      <= 1'b1;
			bit_timeout <= 1'b0;
			scl_oe      <= 1'b0;
			sda_oe      <= 1'b0;
		end else begin
			scl_oe   <= next_scl_low;
			sda_oe   <= next_sda_low;
			bit_done <= 1'b0;
			tcnt     <= wait_scl ? tcnt + 1'b1 : '0;
			if (!running && bit_go) begin
				// take a new operation
				state       <= BE_RUN;
				op          <= bit_op;
				tx          <= bit_tx;
				phase       <= 2'h0;
				qcnt        <= imea_pkg::QTR_LOAD;
				bit_timeout <= 1'b0;
			end else if (tmo_hit) begin
				// scl held low too long: report as no acknowledge
				state       <= BE_IDLE;
				bit_done    <= 1'b1;
				bit_rx      <= imea_pkg::NACK_BIT;
				bit_timeout <= 1'b1; // R20
				held        <= (op != imea_pkg::IMEA_BIT_STOP);
			end else if (running) begin
				qcnt <= (qcnt == '0) ? (wait_scl ? qcnt : imea_pkg::QTR_LOAD) : qcnt - 1'b1;
				if (q_end && phase == 2'h2) begin
					bit_rx <= sda_s; // sample at the end of scl high, just before it is pulled low
				end
				if (q_end) begin
					phase <= phase + 2'h1;
					if (phase == 2'h3) begin
						state    <= BE_IDLE;
						bit_done <= 1'b1;
						held     <= (op != imea_pkg::IMEA_BIT_STOP);
					end
				end
			end
		end
	end
endmodule // imea_bit_engine
`default_nettype wire

// >>> verilog/imea_master.sv
// i2c master command engine: read, write and stop over a byte data memory array
// Contract
// R1: read sends start, address, direction high
// R2: received bytes fill consecutive memory locations
// R3: read ends with its own stop
// R4: eight data clocks per byte
// R5: stop command puts stop on bus
// R6: first memory answers 50h and 51h
// R7: optional memory answers 52h and 53h
// R8: single byte write is four bytes
// R9: page write takes up to 256 bytes
// R10: page write stays within one page; the engine does not enforce it, the caller must
// R11: page bytes stored at consecutive locations
// R12: host closes every memory write with stop
// R13: random read is address write then read
// R14: memory pointer advances per byte read
// R15: pointer stays after last byte read
// R16: acknowledge all read bytes but last
// R17: write sends start, address low, no stop
// R18: report acknowledge one, timeout zero
// R19: no address acknowledge sends stop, aborts
// R20: acknowledge wait bounded by timeout counter
`timescale 1ns/1ps
`default_nettype none
module imea_master #(
	parameter int unsigned ACK_TIMEOUT_CYCLES = imea_pkg::ACK_TIMEOUT_CYCLES
) (
	input  wire logic                       clk,                   // 25 MHz clock
	input  wire logic                       rst_n,                 // async reset, active low
	input  wire logic                       cmd_valid,             // command offered
	output logic                            cmd_ready,             // engine idle, command taken
	input  wire logic [1:0]                 cmd_op,                // write, read or stop
	input  wire logic [6:0]                 target_device_address, // 7-bit slave address
	input  wire logic [imea_pkg::IDX_W-1:0] cmd_start,             // first memory index
	input  wire logic [imea_pkg::CNT_W-1:0] cmd_count,             // bytes to move
	output logic                            cmd_done,              // pulse when command ends
	output logic                            ack_ok,                // 1 acknowledged, 0 none
	output logic                            busy,                  // command in progress
	input  wire logic                       mem_wr,                // user write strobe
	input  wire logic [imea_pkg::IDX_W-1:0] mem_addr,              // user index
	input  wire logic [7:0]                 mem_wdata,             // user write data
	output logic [7:0]                      mem_rdata,             // user read data, one cycle later
	input  wire logic                       scl_i,                 // scl pin level
	output logic                            scl_o,                 // scl drive value, always low
	output logic                            scl_oe,                // scl pulled low
	input  wire logic                       sda_i,                 // sda pin level
	output logic                            sda_o,                 // sda drive value, always low
	output logic                            sda_oe                 // sda pulled low
);
	// ==========================================================
	// declarations
	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_MACK
	} imea_state_t;
	imea_state_t                state;      // byte level sequencer
	logic                       stopping;   // stop bit outstanding
	logic                       pending;    // bit operation in flight
	logic                       is_read;    // latched direction
	logic [6:0]                 dev;        // latched slave address
	logic [imea_pkg::IDX_W-1:0] idx;        // current memory index
	logic [imea_pkg::CNT_W-1:0] remain;     // bytes still to move
	logic [7:0]                 shreg;      // byte being shifted
	logic [2:0]                 bitn;       // bit number within byte
	logic [7:0]                 dm [imea_pkg::DM_DEPTH]; // data memory array
	logic                       bit_done, bit_rx, bit_timeout;
	imea_pkg::imea_bit_t        bit_op;
	logic                       bit_tx;

	// ==========================================================
	// decode
	function automatic logic last_byte(input logic [imea_pkg::CNT_W-1:0] n);
		last_byte = (n == imea_pkg::CNT_ONE);
	endfunction

	wire active    = (state != ST_IDLE) || stopping;
	wire bit_go    = active && !pending;
	wire cmd_take  = cmd_valid && cmd_ready;
	wire got_ack   = (bit_rx == imea_pkg::ACK_BIT) && !bit_timeout;
	wire byte_end  = (bitn == imea_pkg::BIT_LAST);
	// engine stores into the array only after a complete received byte
	wire dm_store  = bit_done && (state == ST_RBYTE) && byte_end;
	wire [7:0] rx_byte = {shreg[6:0], bit_rx};

	assign cmd_ready = !active && !pending;
	assign busy      = active;
	assign scl_o     = 1'b0; // open drain: only ever pulls low
	assign sda_o     = 1'b0;

	// bit request for the current state
	always_comb begin
		bit_op = imea_pkg::IMEA_BIT_DATA;
		bit_tx = imea_pkg::NACK_BIT;
		if (stopping) begin
			bit_op = imea_pkg::IMEA_BIT_STOP;
		end else begin
			case (state)
				ST_START: bit_op = imea_pkg::IMEA_BIT_START;
				ST_ADDR:  bit_tx = shreg[7];
				ST_WBYTE: bit_tx = shreg[7];
				ST_MACK:  bit_tx = last_byte(remain) ? imea_pkg::NACK_BIT : imea_pkg::ACK_BIT; // R16
				default:  bit_tx = imea_pkg::NACK_BIT; // released for acks and reads
			endcase
		end
	end

	// ==========================================================
	// bit engine
	imea_bit_engine #(
		.TIMEOUT_CYCLES (ACK_TIMEOUT_CYCLES)
	) u_bit (
		.clk         (clk),
		.rst_n       (rst_n),
		.bit_go      (bit_go),
		.bit_op      (bit_op),
		.bit_tx      (bit_tx),
		.bit_done    (bit_done),
		.bit_rx      (bit_rx),
		.bit_timeout (bit_timeout),
		.scl_i       (scl_i),
		.sda_i       (sda_i),
		.scl_oe      (scl_oe),
		.sda_oe      (sda_oe)
	);

	// ==========================================================
	// data memory array; a received byte wins over a user write in the same cycle
	always_ff @(posedge clk) begin
		if (dm_store) begin
			dm[idx] <= rx_byte; // R2
		end else if (mem_wr) begin
			dm[mem_addr] <= mem_wdata;
		end
		mem_rdata <= dm[mem_addr];
	end

	// ==========================================================
	// bit request handshake with the engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else begin
			pending <= bit_done ? 1'b0 : (pending || bit_go);
		end
	end

	// ==========================================================
	// byte sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			stopping <= 1'b0;
			is_read  <= 1'b0;
			dev      <= 7'h00;
			idx      <= '0;
			remain   <= imea_pkg::CNT_ZERO;
			shreg    <= 8'h00;
			bitn     <= 3'h0;
			ack_ok   <= 1'b0;
			cmd_done <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			if (cmd_take) begin
				// latch the command; a stop command only needs the stop bit
				is_read <= (cmd_op == imea_pkg::CMD_READ);
				dev     <= target_device_address;
				idx     <= cmd_start;
				remain  <= cmd_count;
				if (cmd_op == imea_pkg::CMD_STOP) begin
					stopping <= 1'b1; // R5
				end else begin
					state <= ST_START; // R1 R17
				end
			end else if (bit_done && stopping) begin
				stopping <= 1'b0;
				cmd_done <= 1'b1;
			end else if (bit_done) begin
				case (state)
					ST_START: begin
						state <= ST_ADDR;
						shreg <= {dev, is_read ? imea_pkg::RW_READ : imea_pkg::RW_WRITE}; // R1 R17
						bitn  <= 3'h0;
					end
					ST_ADDR: begin
						shreg <= {shreg[6:0], 1'b0};
						bitn  <= bitn + 3'h1;
						if (byte_end) begin
							state <= ST_AACK;
						end
					end
					ST_AACK: begin
						ack_ok <= got_ack; // R18
						bitn   <= 3'h0;
						if (!got_ack) begin
							// nobody answered: release the bus and give up
							state    <= ST_IDLE;
							stopping <= 1'b1; // R19
						end else if (remain == imea_pkg::CNT_ZERO) begin
							state    <= ST_IDLE;
							stopping <= is_read;
							cmd_done <= !is_read;
						end else if (is_read) begin
							state <= ST_RBYTE;
						end else begin
							state <= ST_WBYTE;
							shreg <= dm[idx];
						end
					end
					ST_WBYTE: begin
						shreg <= {shreg[6:0], 1'b0};
						bitn  <= bitn + 3'h1;
						if (byte_end) begin
							state <= ST_WACK;
						end
					end
					ST_WACK: begin
						// bytes go out exactly as given; keeping a page write inside
						// one eeprom page is left to the caller
						ack_ok <= got_ack; // R18 R10
						idx    <= idx + imea_pkg::IDX_ONE;
						remain <= remain - imea_pkg::CNT_ONE;
						bitn   <= 3'h0;
						if (!got_ack) begin
							state    <= ST_IDLE;
							stopping <= 1'b1;
						end else if (last_byte(remain)) begin
							// bus stays held so a read may follow at once
							state    <= ST_IDLE;
							cmd_done <= 1'b1; // R17
						end else begin
							state <= ST_WBYTE;
							shreg <= dm[idx + imea_pkg::IDX_ONE];
						end
					end
					ST_RBYTE: begin
						shreg <= rx_byte;
						bitn  <= bitn + 3'h1;
						if (byte_end) begin
							state <= ST_MACK; // R4
						end
					end
					ST_MACK: begin
						idx    <= idx + imea_pkg::IDX_ONE; // R2
						remain <= remain - imea_pkg::CNT_ONE;
						bitn   <= 3'h0;
						if (last_byte(remain)) begin
							state    <= ST_IDLE;
							stopping <= 1'b1; // R3
						end else begin
							state <= ST_RBYTE;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // imea_master
`default_nettype wire

// >>> bench/imea_master_properties.sv
// concurrent checks on the ports of the i2c master command engine
`timescale 1ns/1ps
`default_nettype none
module imea_master_checker #(
	parameter int unsigned ACK_TIMEOUT_CYCLES = 200
) (
	input wire logic                       clk,        // system clock
	input wire logic                       rst_n,      // async reset, active low
	input wire logic                       cmd_valid,  // command offered
	input wire logic                       cmd_ready,  // engine idle
	input wire logic [1:0]                 cmd_op,     // command code
	input wire logic                       cmd_done,   // end pulse
	input wire logic                       ack_ok,     // last ack seen
	input wire logic                       busy,       // command running
	input wire logic                       mem_wr,     // user write strobe
	input wire logic [imea_pkg::IDX_W-1:0] mem_addr,   // user index
	input wire logic [7:0]                 mem_wdata,  // user write data
	input wire logic [7:0]                 mem_rdata,  // user read data
	input wire logic                       scl_i,      // scl bus level
	input wire logic                       scl_oe,     // scl pulled low
	input wire logic                       sda_oe      // sda pulled low
);
	// ==========================================================
	// helper logic
	logic [1:0]  op_q;    // code of the command last taken
	logic [15:0] stretch; // cycles scl has been released but low
	logic        take;    // command taken this edge
	assign take = cmd_valid && cmd_ready;
	// remember which command a done pulse belongs to
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) op_q <= 2'h0;
		else if (take) op_q <= cmd_op;
	end
	// a fresh bit pulls scl low, so the count restarts per bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) stretch <= 16'h0000;
		else if (busy && !scl_oe && !scl_i) stretch <= stretch + 16'h0001;
		else stretch <= 16'h0000;
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	done_pulse_a: assert property (cmd_done |=> !cmd_done)
		else $error("done pulse longer than one cycle");
	busy_ready_a: assert property (busy |-> !cmd_ready)
		else $error("ready while busy");
	take_busy_a: assert property (take |=> busy && !cmd_ready)
		else $error("taken command not running");
	reset_idle_a: assert property ($rose(rst_n) |-> !scl_oe && !sda_oe && !busy)
		else $error("bus held after reset");
	start_cond_a: assert property (take && cmd_op != imea_pkg::CMD_STOP |-> ##[1:600] ($rose(sda_oe) && !scl_oe))
		else $error("no start condition");
	read_stop_a: assert property (cmd_done && op_q == imea_pkg::CMD_READ |-> ##1 (!scl_oe && !sda_oe))
		else $error("read left bus held");
	stop_cmd_a: assert property (cmd_done && op_q == imea_pkg::CMD_STOP |-> ##1 (!scl_oe && !sda_oe))
		else $error("stop left bus held");
	write_hold_a: assert property (cmd_done && op_q == imea_pkg::CMD_WRITE |-> scl_oe || !ack_ok)
		else $error("acked write released scl");
	ack_bound_a: assert property (stretch <= 16'(ACK_TIMEOUT_CYCLES + 8))
		else $error("scl wait not bounded");
	mem_read_a: assert property (mem_wr && !busy ##1 (!mem_wr && !busy && mem_addr == $past(mem_addr))
		|=> mem_rdata == $past(mem_wdata, 2))
		else $error("array read mismatch");
	read_done_c: cover property (cmd_done && op_q == imea_pkg::CMD_READ);
	nack_done_c: cover property (cmd_done && !ack_ok);
	write_held_c: cover property (cmd_done && op_q == imea_pkg::CMD_WRITE && scl_oe);
endmodule // imea_master_checker
bind imea_master imea_master_checker #(.ACK_TIMEOUT_CYCLES(ACK_TIMEOUT_CYCLES)) u_chk (
	.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
	.cmd_done(cmd_done), .ack_ok(ack_ok), .busy(busy), .mem_wr(mem_wr), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire

// >>> bench/imea_ee_model.sv
// behavioural serial eeprom answering on the i2c bus
`timescale 1ns/1ps
`default_nettype none
module imea_ee_model (
	input  wire logic scl,    // scl bus level
	input  wire logic sda,    // sda bus level
	input  wire logic slow,   // stretch scl after each fall
	output logic      scl_oe, // scl pulled low
	output logic      sda_oe  // sda pulled low
);
	logic [7:0]  mem [int];  // sparse storage, key is bank and pointer
	logic [7:0]  pend [$];   // page bytes kept until stop
	logic [7:0]  sh;         // receive shift register
	logic [7:0]  tx;         // byte being sent
	logic [6:0]  dev;        // selected bank address
	logic [15:0] ptr;        // internal address pointer
	logic        mack;       // master acked last byte
	logic        first;      // first byte of a read
	int          bitc;       // bit position, 8 is the ack clock
	int          phase;      // 0 idle 1 addr 2 hi 3 lo 4 data 5 read
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		phase = 0;
		bitc = 0;
	end
	// unwritten places read as a pattern so stale data shows
	function automatic logic [7:0] rd(input int k);
		return mem.exists(k) ? mem[k] : 8'(k) ^ 8'h5A;
	endfunction
	// start: frame begins, a page not yet closed is dropped
	always @(negedge sda) if (scl === 1'b1) begin
		phase = 1;
		bitc = 0;
		pend.delete();
	end
	// stop commits the page, wrapping inside it; phase is kept on purpose
	always @(posedge sda) if (scl === 1'b1) begin
		foreach (pend[i]) mem[int'({dev[1:0], ptr[15:8], 8'(ptr[7:0] + i)})] = pend[i];
		pend.delete();
	end
	// sample on the rising clock
	always @(posedge scl) if (phase != 0) begin
		if (bitc < 8) sh = {sh[6:0], sda};
		else mack = !sda;
		bitc = (bitc == 8) ? 0 : bitc + 1;
	end
	// drive on the falling clock
	always @(negedge scl) if (phase != 0) begin
		if (bitc == 8) begin
			case (phase)
				1: if (sh[7:1] >= 7'h50 && sh[7:1] <= 7'h53) begin
					dev = sh[7:1];
					phase = sh[0] ? 5 : 2;
					first = 1'b1;
					sda_oe = 1'b1;
				end else begin
					phase = 0;
					sda_oe = 1'b0;
				end
				2: begin ptr[15:8] = sh; phase = 3; sda_oe = 1'b1; end
				3: begin ptr[7:0] = sh; phase = 4; sda_oe = 1'b1; end
				4: begin pend.push_back(sh); sda_oe = 1'b1; end
				default: sda_oe = 1'b0;
			endcase
		end else if (phase == 5 && bitc == 0) begin
			if (first || mack) begin
				tx = rd(int'({dev[1:0], ptr}));
				ptr = ptr + 16'h0001;
				first = 1'b0;
				sda_oe = !tx[7];
			end else begin
				phase = 0;
				sda_oe = 1'b0;
			end
		end else if (phase == 5) sda_oe = !tx[7 - bitc];
		else sda_oe = 1'b0;
	end
	// slow answer: hold scl low a while after each fall
	always @(negedge scl) if (slow) begin
		scl_oe = 1'b1;
		#3000;
		scl_oe = 1'b0;
	end
endmodule // imea_ee_model
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking testbench for the i2c master command engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk, rst_n, cmd_valid, mem_wr, slow, hang;
	logic [1:0] cmd_op;
	logic [6:0] tgt;
	logic [7:0] cmd_start, mem_addr, mem_wdata;
	logic [8:0] cmd_count;
	wire logic  cmd_ready, cmd_done, ack_ok, busy, scl_oe, sda_oe, ee_scl_oe, ee_sda_oe, scl_w, sda_w;
	wire logic [7:0] mem_rdata;
	int         err_count, checked, cyc, edges;
	// open-drain bus with pull-ups
	assign scl_w = !(scl_oe || ee_scl_oe || hang);
	assign sda_w = !(sda_oe || ee_sda_oe);
	imea_master #(.ACK_TIMEOUT_CYCLES(200)) DUT (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .target_device_address(tgt), .cmd_start(cmd_start),
		.cmd_count(cmd_count), .cmd_done(cmd_done), .ack_ok(ack_ok), .busy(busy), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .scl_i(scl_w), .scl_o(),
		.scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
	imea_ee_model EE (.scl(scl_w), .sda(sda_w), .slow(slow), .scl_oe(ee_scl_oe), .sda_oe(ee_sda_oe));
	// ==========================================================
	// clock, hang guard and scl rises counted from each start
	initial begin clk = 1'b0; forever #20 clk = ~clk; end
	always @(posedge clk) begin cyc++; if (cyc == 80000) begin err_count++; conclude(); end end
	always @(negedge sda_w) if (scl_w === 1'b1) edges = 0;
	always @(posedge scl_w) edges++;
	// ==========================================================
	// shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk); mem_wr = 1'b1; mem_addr = a; mem_wdata = d;
		@(negedge clk); mem_wr = 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk); mem_addr = a;
		@(negedge clk); chk(mem_rdata, exp);
	endtask
	// held for one clock edge, done awaited
	task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [7:0] s, input logic [8:0] n);
		int i;
		@(negedge clk); cmd_valid = 1'b1; cmd_op = op; tgt = a; cmd_start = s; cmd_count = n;
		@(negedge clk); cmd_valid = 1'b0;
		for (i = 0; i < 20000; i++) begin @(negedge clk); if (cmd_done === 1'b1) break; end
		chk({7'h00, cmd_done}, 8'h01);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_page;
		wr(8'h00, 8'h4D); wr(8'h01, 8'hA4); wr(8'h02, 8'h11); wr(8'h03, 8'h22); wr(8'h04, 8'h33);
		cmd(imea_pkg::CMD_WRITE, 7'h50, 8'h00, 9'h005);
		chk({7'h00, ack_ok}, 8'h01);
		chk({7'h00, scl_oe}, 8'h01);
		cmd(imea_pkg::CMD_STOP, 7'h50, 8'h00, 9'h000);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		$display("page write test ended");
	endtask
	task automatic t_rand;
		wr(8'h05, 8'h4D); wr(8'h06, 8'hA3);
		cmd(imea_pkg::CMD_WRITE, 7'h50, 8'h05, 9'h002);
		cmd(imea_pkg::CMD_READ, 7'h50, 8'hFE, 9'h003);
		rdchk(8'hFE, 8'hF9);
		rdchk(8'hFF, 8'h11);
		rdchk(8'h00, 8'h22);
		chk(8'(EE.phase), 8'h00);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		$display("random read test ended");
	endtask
	task automatic t_seq;
		slow = 1'b1;
		cmd(imea_pkg::CMD_READ, 7'h50, 8'h10, 9'h002);
		slow = 1'b0;
		chk(8'(edges), 8'd28);
		rdchk(8'h10, 8'h33);
		rdchk(8'h11, 8'hFD);
		$display("sequential read test ended");
	endtask
	task automatic t_tmo;
		fork
			cmd(imea_pkg::CMD_READ, 7'h50, 8'h20, 9'h001);
			@(negedge sda_w) @(negedge clk) hang = 1'b1;
		join
		hang = 1'b0;
		chk({7'h00, ack_ok}, 8'h00);
		$display("timeout test ended");
	endtask
	task automatic t_nack;
		cmd(imea_pkg::CMD_WRITE, 7'h54, 8'h00, 9'h001);
		chk({7'h00, ack_ok}, 8'h00);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		$display("no acknowledge test ended");
	endtask
	task automatic t_banks;
		for (int a = 'h51; a <= 'h53; a++) begin
			cmd(imea_pkg::CMD_WRITE, 7'(a), 8'h00, 9'h000);
			chk({7'h00, ack_ok}, 8'h01);
			cmd(imea_pkg::CMD_STOP, 7'(a), 8'h00, 9'h000);
		end
		$display("bank address test ended");
	endtask
	// ==========================================================
	// closing report, the single exit of the run
	task automatic conclude;
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// three cycles of reset, then the scenarios
	initial begin
		rst_n = 1'b0; cmd_valid = 1'b0; mem_wr = 1'b0; slow = 1'b0; hang = 1'b0; cmd_op = 2'h0; tgt = 7'h00;
		cmd_start = 8'h00; mem_addr = 8'h00; mem_wdata = 8'h00; cmd_count = 9'h000;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_page();
		t_rand();
		t_seq();
		t_tmo();
		t_nack();
		t_banks();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
